// File: logic/tributary_overhead_pkg.sv
// Purpose: Constants and types for the tributary overhead control block.
// Assumes: Registers sit on a 32-bit APB; the byte address is four times the register index.
// Notes: Frame and multiframe timing arrive as strobes from the add and drop bus timing logic.
package tributary_overhead_pkg;

	localparam int NUM_PORTS   = 4;
	localparam int ADDR_WIDTH  = 12;
	localparam int DATA_WIDTH  = 32;
	localparam int REG_WIDTH   = 8;
	localparam int INDEX_WIDTH = 10;
	localparam int K4_WIDTH    = 3;

	// Register indexes; byte address is index times four.
	localparam logic [INDEX_WIDTH-1:0] TC_CTRL_INDEX [NUM_PORTS] =
		'{10'h051, 10'h081, 10'h0b1, 10'h0e1};
	localparam logic [INDEX_WIDTH-1:0] RESET_FORCE_INDEX [NUM_PORTS] =
		'{10'h052, 10'h082, 10'h0b2, 10'h0e2};
	localparam logic [INDEX_WIDTH-1:0] QUALIFIER_INDEX = 10'h040;
	localparam logic [INDEX_WIDTH-1:0] STATUS_INDEX    = 10'h041;

	// Control register fields.
	localparam int CTRL_RDIC_BIT       = 0;
	localparam int CTRL_LINE_AIS_BIT   = 1;
	localparam int CTRL_ODI_ENABLE_BIT = 2;
	localparam int CTRL_TANDEM_BIT     = 4;
	localparam int CTRL_FORCE_ODI_BIT  = 6;
	localparam logic [REG_WIDTH-1:0] CTRL_RESET_VALUE = 8'h00;

	// Reset and force register fields.
	localparam int FORCE_BIP_BIT      = 1;
	localparam int COUNTER_RESET_BIT  = 6;
	localparam int SELECT_RESET_BIT   = 7;

	// Qualifier register fields.
	localparam int QUAL_UPSTREAM_AIS_BIT = 0;
	localparam int QUAL_MF_ERROR_BIT     = 1;
	localparam int QUAL_UNEQUIPPED_BIT   = 2;
	localparam int QUAL_TRACE_BIT        = 3;
	localparam logic [REG_WIDTH-1:0] QUAL_RESET_VALUE = 8'h00;

	// K4 bits 5, 6 and 7 while a connectivity defect is sent.
	localparam logic [K4_WIDTH-1:0] K4_RDIC_PATTERN = 3'h6;

	// Selective reset sequencer states.
	typedef enum logic [1:0] {
		PHASE_IDLE  = 2'h1,
		PHASE_CLEAR = 2'h2
	} reset_phase_t;

endpackage

// File: logic/port_register_pair.sv
// Purpose: Holds one port's control register and its self-clearing reset and force register.
// Assumes: Write strobes are single-cycle pulses from the APB access phase.
// Notes: A write of one always wins over a self-clear in the same cycle.
module port_register_pair
	import tributary_overhead_pkg::*;
(
	// Clock and reset.
	input  wire logic                 clock,
	input  wire logic                 reset,
	// Register writes.
	input  wire logic                 ctrl_write,
	input  wire logic                 force_write,
	input  wire logic [REG_WIDTH-1:0] write_byte,
	// Transmit timing.
	input  wire logic                 v5_tx_slot,
	// Register contents and reset pulses.
	output logic      [REG_WIDTH-1:0] ctrl_value,
	output logic      [REG_WIDTH-1:0] force_value,
	output logic                      alarm_clear,
	output logic                      counter_clear
);

	reset_phase_t phase;
	reset_phase_t next_phase;
	logic         port_selective_reset;
	logic         port_counter_reset;
	logic         force_parity_pair_error;
	logic         next_selective;
	logic         next_counter;
	logic         next_parity;
	logic         clearing;

	// Reset bits enter a one-cycle clear phase, then drop unless written again.
	assign clearing       = (phase == PHASE_CLEAR);
	assign next_phase     = (!clearing && (port_selective_reset || port_counter_reset))
		? PHASE_CLEAR : PHASE_IDLE;
	assign next_selective = (force_write && write_byte[SELECT_RESET_BIT])
		|| (port_selective_reset && !clearing);
	assign next_counter   = (force_write && write_byte[COUNTER_RESET_BIT])
		|| (port_counter_reset && !clearing);
	assign next_parity    = (force_write && write_byte[FORCE_BIP_BIT])
		|| (force_parity_pair_error && !v5_tx_slot);

	// Selective reset clears alarms and FIFOs; both resets clear counters.
	assign alarm_clear   = clearing && port_selective_reset;
	assign counter_clear = clearing && (port_selective_reset || port_counter_reset);

	// Unused bits read as zero whatever was written.
	always_comb
	begin
		force_value                    = '0;
		force_value[SELECT_RESET_BIT]  = port_selective_reset;
		force_value[COUNTER_RESET_BIT] = port_counter_reset;
		force_value[FORCE_BIP_BIT]     = force_parity_pair_error;
	end

	// Control bits survive the selective reset.
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			phase                   <= PHASE_IDLE;
			ctrl_value              <= CTRL_RESET_VALUE;
			port_selective_reset    <= 1'b0;
			port_counter_reset      <= 1'b0;
			force_parity_pair_error <= 1'b0;
		end
		else
		begin
			phase                   <= next_phase;
			if (ctrl_write)
				ctrl_value <= write_byte;
			port_selective_reset    <= next_selective;
			port_counter_reset      <= next_counter;
			force_parity_pair_error <= next_parity;
		end
	end

endmodule // port_register_pair

// File: logic/port_overhead_unit.sv
// Purpose: Per-port ODI latch, receive line AIS and RDIC insertion values.
// Assumes: Strobes are one cycle wide and synchronous to clock.
// Notes: All outputs come from flip-flops.
module port_overhead_unit
	import tributary_overhead_pkg::*;
(
	// Clock and reset.
	input  wire logic                clock,
	input  wire logic                reset,
	// Port control.
	input  wire logic                tandem_feature_enable,
	input  wire logic                tc_outgoing_defect_enable,
	input  wire logic                force_outgoing_defect,
	input  wire logic                tc_line_ais_enable,
	input  wire logic                tx_connectivity_defect_send,
	input  wire logic                alarm_clear,
	// Qualified alarms and timing.
	input  wire logic                odi_alarm,
	input  wire logic                rx_tc_alarm,
	input  wire logic                multiframe_strobe,
	input  wire logic                odi_frame_slot,
	// Overhead values.
	output logic                     outgoing_defect_bit,
	output logic                     rx_line_ais,
	output logic                     v5_rdi_bit,
	output logic      [K4_WIDTH-1:0] k4_rdic_bits
);

	logic odi_sample;
	logic odi_set;
	logic odi_hold;
	logic next_odi;

	// Force needs only the tandem enable; alarms also need the outgoing defect enable.
	assign odi_sample = tandem_feature_enable && (force_outgoing_defect
		|| (tc_outgoing_defect_enable && odi_alarm));
	assign odi_set    = multiframe_strobe && odi_sample;
	assign odi_hold   = outgoing_defect_bit && !(odi_frame_slot && !odi_sample);
	assign next_odi   = tandem_feature_enable && !alarm_clear && (odi_set || odi_hold);

	// ODI latch, receive line AIS and insertion values for the add bus.
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			outgoing_defect_bit <= 1'b0;
			rx_line_ais         <= 1'b0;
			v5_rdi_bit          <= 1'b0;
			k4_rdic_bits        <= '0;
		end
		else
		begin
			outgoing_defect_bit <= next_odi;
			rx_line_ais         <= tandem_feature_enable && tc_line_ais_enable
				&& rx_tc_alarm && !alarm_clear;
			v5_rdi_bit          <= tx_connectivity_defect_send;
			k4_rdic_bits        <= tx_connectivity_defect_send ? K4_RDIC_PATTERN : '0;
		end
	end

endmodule // port_overhead_unit

// File: logic/tributary_overhead_control.sv
// Purpose: Four-port tandem connection and overhead control with an APB register slave.
// Assumes: Alarm inputs are levels from the drop bus detectors, one bit per port.
// Notes: APB answers with no wait states; read data is captured in the setup cycle.
//
// Our own choice: the APB interface to the registers.
module tributary_overhead_control
	import tributary_overhead_pkg::*;
(
	// Clock and reset.
	input  wire logic                  clock,
	input  wire logic                  reset,
	// APB slave.
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic [DATA_WIDTH-1:0] pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [DATA_WIDTH-1:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Frame timing per port.
	input  wire logic [NUM_PORTS-1:0]  multiframe_strobe,
	input  wire logic [NUM_PORTS-1:0]  odi_frame_slot,
	input  wire logic [NUM_PORTS-1:0]  v5_tx_slot,
	// Drop bus A alarms.
	input  wire logic [NUM_PORTS-1:0]  drop_a_pointer_loss,
	input  wire logic [NUM_PORTS-1:0]  drop_a_tu_ais,
	input  wire logic [NUM_PORTS-1:0]  drop_a_label_mismatch,
	input  wire logic [NUM_PORTS-1:0]  drop_a_tc_unequipped,
	input  wire logic [NUM_PORTS-1:0]  drop_a_tc_ais,
	input  wire logic [NUM_PORTS-1:0]  drop_a_tc_trace_lock_loss,
	input  wire logic [NUM_PORTS-1:0]  drop_a_tc_multiframe_loss,
	input  wire logic [NUM_PORTS-1:0]  drop_a_bus_ais,
	input  wire logic [NUM_PORTS-1:0]  drop_a_multiframe_error,
	input  wire logic [NUM_PORTS-1:0]  drop_a_unequipped,
	input  wire logic [NUM_PORTS-1:0]  drop_a_trace_alarm,
	// Drop bus B alarms.
	input  wire logic [NUM_PORTS-1:0]  drop_b_pointer_loss,
	input  wire logic [NUM_PORTS-1:0]  drop_b_tu_ais,
	input  wire logic [NUM_PORTS-1:0]  drop_b_label_mismatch,
	input  wire logic [NUM_PORTS-1:0]  drop_b_tc_unequipped,
	input  wire logic [NUM_PORTS-1:0]  drop_b_tc_ais,
	input  wire logic [NUM_PORTS-1:0]  drop_b_tc_trace_lock_loss,
	input  wire logic [NUM_PORTS-1:0]  drop_b_tc_multiframe_loss,
	input  wire logic [NUM_PORTS-1:0]  drop_b_bus_ais,
	input  wire logic [NUM_PORTS-1:0]  drop_b_multiframe_error,
	input  wire logic [NUM_PORTS-1:0]  drop_b_unequipped,
	input  wire logic [NUM_PORTS-1:0]  drop_b_trace_alarm,
	// Add bus overhead values.
	output logic      [NUM_PORTS-1:0]  outgoing_defect_bit,
	output logic      [NUM_PORTS-1:0]  v5_rdi_bit,
	output logic [K4_WIDTH*NUM_PORTS-1:0] k4_rdic_bits,
	output logic      [NUM_PORTS-1:0]  bip2_invert,
	// Receive line and port maintenance.
	output logic      [NUM_PORTS-1:0]  rx_line_ais,
	output logic      [NUM_PORTS-1:0]  port_alarm_clear,
	output logic      [NUM_PORTS-1:0]  port_counter_clear,
	output logic      [NUM_PORTS-1:0]  port_fifo_init
);

	logic [INDEX_WIDTH-1:0] reg_index;
	logic                   setup_phase;
	logic                   write_access;
	logic                   low_lane;
	logic [NUM_PORTS-1:0]   ctrl_hit;
	logic [NUM_PORTS-1:0]   force_hit;
	logic                   qualifier_hit;
	logic                   status_hit;
	logic                   mapped;
	logic [REG_WIDTH-1:0]   write_byte;
	logic [REG_WIDTH-1:0]   read_byte;
	logic [REG_WIDTH-1:0]   status_value;
	logic [REG_WIDTH-1:0]   qualifier;
	logic [REG_WIDTH-1:0]   ctrl_value [NUM_PORTS];
	logic [REG_WIDTH-1:0]   force_value [NUM_PORTS];
	logic [NUM_PORTS-1:0]   alarm_clear;
	logic [NUM_PORTS-1:0]   odi_alarm;
	logic [NUM_PORTS-1:0]   rx_tc_alarm;
	logic [NUM_PORTS-1:0]   always_counted;
	logic [NUM_PORTS-1:0]   qualified_counted;
	logic                   upstream_ais_qualifier;
	logic                   multiframe_error_select;
	logic                   unequipped_qualifier;
	logic                   trace_alarm_enable;

	// APB phase and address decode.
	assign reg_index     = paddr[ADDR_WIDTH-1:2];
	assign setup_phase   = psel && !penable;
	assign write_access  = psel && penable && pwrite;
	assign low_lane      = pstrb[0];
	assign write_byte    = pwdata[REG_WIDTH-1:0];
	assign qualifier_hit = (reg_index == QUALIFIER_INDEX);
	assign status_hit    = (reg_index == STATUS_INDEX);
	assign mapped        = (|ctrl_hit) || (|force_hit) || qualifier_hit || status_hit;
	assign pready        = 1'b1;

	// Qualifier fields shared by all ports.
	assign upstream_ais_qualifier  = qualifier[QUAL_UPSTREAM_AIS_BIT];
	assign multiframe_error_select = qualifier[QUAL_MF_ERROR_BIT];
	assign unequipped_qualifier    = qualifier[QUAL_UNEQUIPPED_BIT];
	assign trace_alarm_enable      = qualifier[QUAL_TRACE_BIT];

	// Receive TC alarms from either drop bus.
	assign rx_tc_alarm = drop_a_tc_unequipped | drop_b_tc_unequipped
		| drop_a_tc_ais | drop_b_tc_ais
		| drop_a_tc_trace_lock_loss | drop_b_tc_trace_lock_loss
		| drop_a_tc_multiframe_loss | drop_b_tc_multiframe_loss;

	// Alarms that always feed the outgoing defect indication.
	assign always_counted = drop_a_pointer_loss | drop_b_pointer_loss
		| drop_a_tu_ais | drop_b_tu_ais
		| drop_a_label_mismatch | drop_b_label_mismatch
		| rx_tc_alarm;

	// Alarms that count only with their qualifier.
	assign qualified_counted =
		({NUM_PORTS{upstream_ais_qualifier}} & (drop_a_bus_ais | drop_b_bus_ais))
		| ({NUM_PORTS{multiframe_error_select}}
			& (drop_a_multiframe_error | drop_b_multiframe_error))
		| ({NUM_PORTS{unequipped_qualifier}} & (drop_a_unequipped | drop_b_unequipped))
		| ({NUM_PORTS{trace_alarm_enable}} & (drop_a_trace_alarm | drop_b_trace_alarm));

	assign odi_alarm = always_counted | qualified_counted;

	// Status shows pending ODI requests and active line AIS.
	assign status_value = {rx_line_ais, outgoing_defect_bit};

	// Per-port registers and overhead logic.
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : g_port
			logic ctrl_write;
			logic force_write;

			assign ctrl_hit[p]  = (reg_index == TC_CTRL_INDEX[p]);
			assign force_hit[p] = (reg_index == RESET_FORCE_INDEX[p]);
			assign ctrl_write   = write_access && low_lane && ctrl_hit[p];
			assign force_write  = write_access && low_lane && force_hit[p];

			// Self-clearing bits and the reset sequencer.
			port_register_pair u_regs (
				.clock         (clock),
				.reset         (reset),
				.ctrl_write    (ctrl_write),
				.force_write   (force_write),
				.write_byte    (write_byte),
				.v5_tx_slot    (v5_tx_slot[p]),
				.ctrl_value    (ctrl_value[p]),
				.force_value   (force_value[p]),
				.alarm_clear   (alarm_clear[p]),
				.counter_clear (port_counter_clear[p])
			);

			// ODI latch, line AIS and RDIC values.
			port_overhead_unit u_overhead (
				.clock                       (clock),
				.reset                       (reset),
				.tandem_feature_enable       (ctrl_value[p][CTRL_TANDEM_BIT]),
				.tc_outgoing_defect_enable   (ctrl_value[p][CTRL_ODI_ENABLE_BIT]),
				.force_outgoing_defect       (ctrl_value[p][CTRL_FORCE_ODI_BIT]),
				.tc_line_ais_enable          (ctrl_value[p][CTRL_LINE_AIS_BIT]),
				.tx_connectivity_defect_send (ctrl_value[p][CTRL_RDIC_BIT]),
				.alarm_clear                 (alarm_clear[p]),
				.odi_alarm                   (odi_alarm[p]),
				.rx_tc_alarm                 (rx_tc_alarm[p]),
				.multiframe_strobe           (multiframe_strobe[p]),
				.odi_frame_slot              (odi_frame_slot[p]),
				.outgoing_defect_bit         (outgoing_defect_bit[p]),
				.rx_line_ais                 (rx_line_ais[p]),
				.v5_rdi_bit                  (v5_rdi_bit[p]),
				.k4_rdic_bits                (k4_rdic_bits[p*K4_WIDTH +: K4_WIDTH])
			);

			// Maintenance pulses and parity inversion level.
			assign port_alarm_clear[p] = alarm_clear[p];
			assign port_fifo_init[p]   = alarm_clear[p];
			assign bip2_invert[p]      = force_value[p][FORCE_BIP_BIT];
		end
	endgenerate

	// Read data selection across all mapped registers.
	always_comb
	begin
		read_byte = '0;
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			if (ctrl_hit[i])
				read_byte = read_byte | ctrl_value[i];
			if (force_hit[i])
				read_byte = read_byte | force_value[i];
		end
		if (qualifier_hit)
			read_byte = read_byte | qualifier;
		if (status_hit)
			read_byte = read_byte | status_value;
	end

	// Shared qualifier register.
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			qualifier <= QUAL_RESET_VALUE;
		else if (write_access && low_lane && qualifier_hit)
			qualifier <= write_byte;
	end

	// Read data and error are captured in setup and held through access.
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (setup_phase)
		begin
			prdata  <= {{(DATA_WIDTH-REG_WIDTH){1'b0}}, read_byte};
			pslverr <= !mapped;
		end
	end

endmodule // tributary_overhead_control

// File: verification/tributary_overhead_checker.sv
// Purpose: Concurrent checks on the ports of the tributary overhead control block.
// Assumes: One clock domain with an asynchronous active-high reset.
// Notes: Slot and ODI checks watch port 1, the port the bench drives hardest.
module tributary_overhead_checker
	import tributary_overhead_pkg::*;
(
	// Clock and reset.
	input wire logic                          clock,
	input wire logic                          reset,
	// APB.
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [ADDR_WIDTH-1:0]         paddr,
	input wire logic                          pslverr,
	// Slot timing.
	input wire logic [NUM_PORTS-1:0]          multiframe_strobe,
	input wire logic [NUM_PORTS-1:0]          odi_frame_slot,
	input wire logic [NUM_PORTS-1:0]          v5_tx_slot,
	// Overhead and maintenance outputs.
	input wire logic [NUM_PORTS-1:0]          outgoing_defect_bit,
	input wire logic [NUM_PORTS-1:0]          v5_rdi_bit,
	input wire logic [K4_WIDTH*NUM_PORTS-1:0] k4_rdic_bits,
	input wire logic [NUM_PORTS-1:0]          bip2_invert,
	input wire logic [NUM_PORTS-1:0]          port_alarm_clear,
	input wire logic [NUM_PORTS-1:0]          port_counter_clear,
	input wire logic [NUM_PORTS-1:0]          port_fifo_init
);
	timeunit 1ns;
	timeprecision 1ps;
	logic                          wr_acc;
	logic                          mapped;
	logic [K4_WIDTH*NUM_PORTS-1:0] k4_exp;
	logic [2:0]                    rise_hist;
	logic [2:0]                    fall_hist;
	// True for every register index the block decodes.
	function automatic logic is_mapped(input logic [INDEX_WIDTH-1:0] i);
		is_mapped = (i == QUALIFIER_INDEX) || (i == STATUS_INDEX);
		for (int p = 0; p < NUM_PORTS; p++)
			if (i == TC_CTRL_INDEX[p] || i == RESET_FORCE_INDEX[p]) is_mapped = 1'b1;
	endfunction
	// Decoded bus phase and the K4 value implied by the V5 RDIC bit.
	assign wr_acc = psel && penable && pwrite;
	assign mapped = is_mapped(paddr[11:2]);
	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_k4
		assign k4_exp[K4_WIDTH*p +: K4_WIDTH] = v5_rdi_bit[p] ? K4_RDIC_PATTERN : '0;
	end
	// Recent causes that may raise or drop the port 1 ODI, so latency slack stays bounded.
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			rise_hist <= '0;
			fall_hist <= '0;
		end
		else
		begin
			rise_hist <= {rise_hist[1:0], multiframe_strobe[0]};
			fall_hist <= {fall_hist[1:0], odi_frame_slot[0] | port_alarm_clear[0] | wr_acc};
		end
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// Relations between the outputs and their causes.
	property p_k4;
		k4_rdic_bits == k4_exp;
	endproperty
	a_k4: assert property (p_k4) else $error("K4 bits disagree with V5 RDI bit");
	property p_clear_pulse;
		$rose(port_alarm_clear[0]) |-> $past(wr_acc, 2) ##1 !port_alarm_clear[0];
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("bad alarm clear pulse");
	property p_fifo;
		port_fifo_init == port_alarm_clear;
	endproperty
	a_fifo: assert property (p_fifo) else $error("FIFO init not with alarm clear");
	property p_counter;
		(port_alarm_clear & ~port_counter_clear) == '0;
	endproperty
	a_counter: assert property (p_counter) else $error("counters kept on port reset");
	property p_bip_clear;
		bip2_invert[0] && v5_tx_slot[0] && !wr_acc |=> !bip2_invert[0];
	endproperty
	a_bip_clear: assert property (p_bip_clear) else $error("BIP force outlived its frame");
	property p_odi_rise;
		$rose(outgoing_defect_bit[0]) |-> rise_hist != 3'h0;
	endproperty
	a_odi_rise: assert property (p_odi_rise) else $error("ODI set without sample");
	property p_odi_fall;
		$fell(outgoing_defect_bit[0]) |-> fall_hist != 3'h0;
	endproperty
	a_odi_fall: assert property (p_odi_fall) else $error("ODI dropped before its slot");
	property p_slverr;
		psel && penable |-> pslverr == !mapped;
	endproperty
	a_slverr: assert property (p_slverr) else $error("slave error disagrees with decode");
endmodule // tributary_overhead_checker

// File: verification/add_bus_model.sv
// Purpose: Add bus timing model that paces overhead slots and records what port 1 sends.
// Assumes: Shares the clock of the control block.
// Notes: Each strobe is a one-cycle pulse launched at a rising edge.
module add_bus_model
	import tributary_overhead_pkg::*;
(
	// Clock.
	input  wire logic                 clock,
	// Slot strobes.
	output logic      [NUM_PORTS-1:0] multiframe_strobe,
	output logic      [NUM_PORTS-1:0] odi_frame_slot,
	output logic      [NUM_PORTS-1:0] v5_tx_slot,
	// Overhead values sent.
	input  wire logic [NUM_PORTS-1:0] outgoing_defect_bit,
	input  wire logic [NUM_PORTS-1:0] bip2_invert
);
	timeunit 1ns;
	timeprecision 1ps;
	logic odi_sent = 1'b0;
	int   inv_frames = 0;
	// Strobes idle low from time zero.
	initial
	begin
		multiframe_strobe = '0;
		odi_frame_slot = '0;
		v5_tx_slot = '0;
	end
	// Pulses one strobe kind (0 multiframe, 1 ODI slot, 2 V5) of one port for one cycle.
	task automatic pulse(input int kind, input int p);
		@(posedge clock);
		case (kind)
			0: multiframe_strobe[p] <= 1'b1;
			1: odi_frame_slot[p] <= 1'b1;
			default: v5_tx_slot[p] <= 1'b1;
		endcase
		@(posedge clock);
		multiframe_strobe <= '0;
		odi_frame_slot <= '0;
		v5_tx_slot <= '0;
	endtask
	// Captures the ODI bit at its slot and counts V5 bytes sent with inverted parity.
	always @(posedge clock)
	begin
		if (odi_frame_slot[0]) odi_sent <= outgoing_defect_bit[0];
		if (v5_tx_slot[0] && bip2_invert[0]) inv_frames <= inv_frames + 1;
	end
endmodule // add_bus_model

// File: verification/tributary_overhead_control_tb.sv
// Purpose: Self-checking bench for the tributary overhead control block.
// Assumes: Registers are reached over APB; slots come from the add bus model.
// Notes: Register access covers all ports; alarm scenarios run on port 1.
module tributary_overhead_control_tb
	import tributary_overhead_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                          clock = 1'b0;
	logic                          reset = 1'b1;
	logic                          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_WIDTH-1:0]         paddr = '0;
	logic [DATA_WIDTH-1:0]         pwdata = '0, prdata, rd;
	logic [3:0]                    pstrb = 4'h0;
	logic                          pready, pslverr, err;
	logic [NUM_PORTS-1:0]          al [22];
	logic [NUM_PORTS-1:0]          mf, slot, v5, odi, rdi, bip, ais, aclr, cclr;
	logic [K4_WIDTH*NUM_PORTS-1:0] k4;
	int                            bad_count = 0, cmp_count = 0, n_ac = 0, n_cc = 0;
	// Design, slot model and clock.
	tributary_overhead_control u_tributary_overhead_control (
		.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .multiframe_strobe(mf), .odi_frame_slot(slot), .v5_tx_slot(v5),
		.drop_a_pointer_loss(al[0]), .drop_a_tu_ais(al[1]), .drop_a_label_mismatch(al[2]),
		.drop_a_tc_unequipped(al[3]), .drop_a_tc_ais(al[4]),
		.drop_a_tc_trace_lock_loss(al[5]), .drop_a_tc_multiframe_loss(al[6]),
		.drop_a_bus_ais(al[7]), .drop_a_multiframe_error(al[8]), .drop_a_unequipped(al[9]),
		.drop_a_trace_alarm(al[10]), .drop_b_pointer_loss(al[11]), .drop_b_tu_ais(al[12]),
		.drop_b_label_mismatch(al[13]), .drop_b_tc_unequipped(al[14]), .drop_b_tc_ais(al[15]),
		.drop_b_tc_trace_lock_loss(al[16]), .drop_b_tc_multiframe_loss(al[17]),
		.drop_b_bus_ais(al[18]), .drop_b_multiframe_error(al[19]), .drop_b_unequipped(al[20]),
		.drop_b_trace_alarm(al[21]), .outgoing_defect_bit(odi), .v5_rdi_bit(rdi),
		.k4_rdic_bits(k4), .bip2_invert(bip), .rx_line_ais(ais), .port_alarm_clear(aclr),
		.port_counter_clear(cclr), .port_fifo_init()
	);
	add_bus_model u_add_bus_model (.clock(clock), .multiframe_strobe(mf), .odi_frame_slot(slot),
		.v5_tx_slot(v5), .outgoing_defect_bit(odi), .bip2_invert(bip));
	always #5 clock = ~clock;
	// Counts maintenance pulses on port 1.
	always @(posedge clock)
	begin
		if (aclr[0]) n_ac++;
		if (cclr[0]) n_cc++;
	end
	// Bus, wait and compare helpers.
	task automatic apb(input logic wr, input logic [INDEX_WIDTH-1:0] idx, input logic [7:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d}; pstrb <= 4'hf;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) bad_count++;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic rdreg(input logic [INDEX_WIDTH-1:0] idx, input logic [7:0] exp, string name);
		apb(1'b0, idx, 8'h00);
		check(name, rd, {24'h0, exp});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	// Raises one alarm, samples it, clears it and lets the ODI slot pass.
	task automatic odi_case(input int k, input logic exp);
		@(posedge clock);
		al[k][0] <= 1'b1;
		u_add_bus_model.pulse(0, 0);
		settle(1);
		check("odi latched", odi[0], exp);
		@(posedge clock);
		al[k][0] <= 1'b0;
		u_add_bus_model.pulse(1, 0);
		settle(1);
		check("odi sent", u_add_bus_model.odi_sent, exp);
		check("odi released", odi[0], 1'b0);
	endtask
	task automatic stop_test();
		if (bad_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence.
	initial
	begin
		foreach (al[i]) al[i] = '0;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			rdreg(TC_CTRL_INDEX[p], CTRL_RESET_VALUE, "ctrl reset");
			rdreg(RESET_FORCE_INDEX[p], 8'h00, "force reset");
			apb(1'b1, TC_CTRL_INDEX[p], 8'h01);
			rdreg(TC_CTRL_INDEX[p], 8'h01, "ctrl readback");
			check("rdi bit", rdi[p], 1'b1);
			check("k4 bits", k4[K4_WIDTH*p +: K4_WIDTH], K4_RDIC_PATTERN);
			apb(1'b1, TC_CTRL_INDEX[p], 8'h00);
		end
		apb(1'b1, 10'h3ff, 8'h5a);
		check("unmapped error", err, 1'b1);
		apb(1'b1, TC_CTRL_INDEX[0], 8'h14);
		for (int k = 0; k < 18; k++)
			if (k < 7 || k > 10) odi_case(k, 1'b1);
		for (int q = 0; q < 4; q++)
		begin
			odi_case(7 + q + 11 * (q % 2), 1'b0);
			apb(1'b1, QUALIFIER_INDEX, 8'h01 << q);
			odi_case(7 + q + 11 * (q % 2), 1'b1);
			apb(1'b1, QUALIFIER_INDEX, 8'h00);
		end
		apb(1'b1, TC_CTRL_INDEX[0], 8'h10);
		odi_case(0, 1'b0);
		apb(1'b1, TC_CTRL_INDEX[0], 8'h50);
		u_add_bus_model.pulse(0, 0);
		u_add_bus_model.pulse(1, 0);
		settle(1);
		check("odi forced", odi[0], 1'b1);
		check("forced odi sent", u_add_bus_model.odi_sent, 1'b1);
		apb(1'b1, TC_CTRL_INDEX[0], 8'h40);
		u_add_bus_model.pulse(0, 0);
		settle(1);
		check("odi without tandem", odi[0], 1'b0);
		apb(1'b1, TC_CTRL_INDEX[0], 8'h12);
		@(posedge clock);
		al[4][0] <= 1'b1;
		settle(2);
		check("line ais", ais[0], 1'b1);
		apb(1'b1, TC_CTRL_INDEX[0], 8'h02);
		settle(1);
		check("line ais no tandem", ais[0], 1'b0);
		apb(1'b1, TC_CTRL_INDEX[0], 8'h14);
		@(posedge clock);
		al[4][0] <= 1'b0;
		al[0][0] <= 1'b1;
		u_add_bus_model.pulse(0, 0);
		apb(1'b1, RESET_FORCE_INDEX[0], 8'h80);
		check("odi before reset", odi[0], 1'b1);
		settle(3);
		check("alarm clears", n_ac, 1);
		check("counter clears", n_cc, 1);
		check("odi after port reset", odi[0], 1'b0);
		rdreg(RESET_FORCE_INDEX[0], 8'h00, "selective self clear");
		rdreg(TC_CTRL_INDEX[0], 8'h14, "ctrl kept");
		apb(1'b1, RESET_FORCE_INDEX[0], 8'h40);
		settle(3);
		check("alarm clears", n_ac, 1);
		check("counter clears", n_cc, 2);
		rdreg(RESET_FORCE_INDEX[0], 8'h00, "counter self clear");
		apb(1'b1, RESET_FORCE_INDEX[0], 8'h02);
		settle(1);
		check("bip armed", bip[0], 1'b1);
		u_add_bus_model.pulse(2, 0);
		u_add_bus_model.pulse(2, 0);
		settle(1);
		check("inverted frames", u_add_bus_model.inv_frames, 1);
		check("bip cleared", bip[0], 1'b0);
		stop_test();
	end
	// Watchdog against a hung handshake.
	initial
	begin
		#100000;
		bad_count++;
		stop_test();
	end
endmodule // tributary_overhead_control_tb
bind tributary_overhead_control tributary_overhead_checker u_tributary_overhead_checker (
	.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pslverr(pslverr), .multiframe_strobe(multiframe_strobe),
	.odi_frame_slot(odi_frame_slot), .v5_tx_slot(v5_tx_slot),
	.outgoing_defect_bit(outgoing_defect_bit), .v5_rdi_bit(v5_rdi_bit),
	.k4_rdic_bits(k4_rdic_bits), .bip2_invert(bip2_invert), .port_alarm_clear(port_alarm_clear),
	.port_counter_clear(port_counter_clear), .port_fifo_init(port_fifo_init)
);
